// *** verilog/pcs_top.sv ***
// Power, reset and charge sequencer of the always-powered supervisor
// Operation
// - Power up and down are event driven: switch on, reset release, soft auto on/off.
// - Power switch falling raises power-off event; rising raises power-on event.
// - Supply enable low switches logic and backed supply on; high removes logic supply.
// - Backup select high picks auxiliary battery, low picks main battery.
// - While backup select is high the display drive voltage stays available.
// - Power-off waits for software to finish, reinitialise and warn before supply drops.
// - Gate-array reset initialises companion chips and expansion port, never switches power.
// - Gate-array reset is active low.
// - Override open: main charge mode low only first eight hours after adaptor connect or soft charge restart.
// - After eight hours main charge mode goes high for trickle charge.
// - Override closed: normal charge continuously while the adaptor is connected.
// - Processor reset output low resets processors, high when inactive.
// - Reset switch low asserts processor reset and gate-array reset.
// - Adaptor detect high means adaptor present and charging possible.
// - Auxiliary charge mode low is normal, high is trickle.
// - Battery sense high routes battery and operating voltage to the converter.
`timescale 1ns/10ps
`default_nettype none
module pcs_top #(
  parameter logic [43:0] CHARGE_CYCLES = 44'(pcs_pkg::PCS_NORMAL_CHG_CYC)
) (
  // Clock and reset
  input  wire logic                             mclk,
  input  wire logic                             sys_rst,
  // Pins from outside the domain
  input  wire pcs_pkg::pcs_pins_type            pins,
  // Register port
  input  wire pcs_pkg::pcs_bus_type             bus,
  output logic      [pcs_pkg::PCS_DATA_W-1:0]   rdata,
  output logic                                  irq,
  // Power and reset drives
  output logic                                  supply_enable_n,
  output logic                                  gate_array_reset_out,
  output logic                                  cpu_reset_n,
  output logic                                  backup_select,
  output logic                                  lcd_drive_en,
  // Charge and measurement drives
  output logic                                  main_charge_mode,
  output logic                                  aux_charge_mode,
  output logic                                  battery_sense_en
);
  import pcs_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisation
  logic [PCS_PINS_W-1:0] pins_sync;
  pcs_pins_type          pin_s;
  pcs_pins_type          pin_d_r;

  pcs_sync #(
    .W       (PCS_PINS_W),
    .RST_VAL (PCS_PINS_RST)
  ) u_sync (
    .mclk     (mclk),
    .sys_rst  (sys_rst),
    .async_in (pins),
    .sync_out (pins_sync)
  );

  assign pin_s = pcs_pins_type'(pins_sync);

  // Previous synchronised level for edge detection
  // Same reset value as the synchroniser, so no false edge follows reset
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      pin_d_r <= pcs_pins_type'(PCS_PINS_RST);
    end else begin
      pin_d_r <= pin_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin events
  wire sw_rise   = pin_s.power_switch_in & ~pin_d_r.power_switch_in;
  wire sw_fall   = ~pin_s.power_switch_in & pin_d_r.power_switch_in;
  wire rst_rel   = pin_s.reset_switch_n & ~pin_d_r.reset_switch_n;
  wire rst_press = ~pin_s.reset_switch_n;
  wire lv_rise   = pin_s.low_volt_det & ~pin_d_r.low_volt_det;
  wire adp_rise  = pin_s.adaptor_present & ~pin_d_r.adaptor_present;
  wire adp_edge  = pin_s.adaptor_present ^ pin_d_r.adaptor_present;

  ////////////////////////////////////////////////////////////////////////////
  // Register decode
  wire wr_ctrl   = bus.wr & (bus.addr == PCS_OFF_CTRL);
  wire wr_cmd    = bus.wr & (bus.addr == PCS_OFF_CMD);
  wire wr_irq_st = bus.wr & (bus.addr == PCS_OFF_IRQ_ST);
  wire wr_irq_mk = bus.wr & (bus.addr == PCS_OFF_IRQ_MK);

  wire cmd_auto_on  = wr_cmd & bus.wdata[PCS_CMD_AUTO_ON];
  wire cmd_auto_off = wr_cmd & bus.wdata[PCS_CMD_AUTO_OFF];
  wire cmd_off_ack  = wr_cmd & bus.wdata[PCS_CMD_OFF_ACK];
  wire cmd_chg_rst  = wr_cmd & bus.wdata[PCS_CMD_CHG_RST];

  logic [PCS_DATA_W-1:0] ctrl_r;
  logic [PCS_IRQ_N-1:0]  irq_st_r;
  logic [PCS_IRQ_N-1:0]  irq_mk_r;

  // Control register, steers backup, aux charge and sense outputs
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl_r <= PCS_CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl_r <= bus.wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Power requests
  // Switch on, reset release and soft wake all request power-on
  wire on_req  = sw_rise | rst_rel | cmd_auto_on;
  // Switch off, low voltage and soft auto-off all request power-off
  wire off_req = sw_fall | lv_rise | cmd_auto_off;

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer
  pcs_state_type        state_r;
  pcs_state_type        state_nxt;
  logic [PCS_TMR_W-1:0] tmr_r;
  logic [PCS_TMR_W-1:0] tmr_nxt;
  logic                 off_pend_r;
  logic                 on_pend_r;

  // Compare against the last count so each wait lasts exactly its constant
  localparam logic [PCS_TMR_W-1:0] SETTLE_LAST = PCS_TMR_W'(PCS_SETTLE_CYC - 1);
  localparam logic [PCS_TMR_W-1:0] LEAD_LAST   = PCS_TMR_W'(PCS_GA_LEAD_CYC - 1);

  wire tmr_settle_done = (tmr_r == SETTLE_LAST);
  wire tmr_lead_done   = (tmr_r == LEAD_LAST);

  // Next-state logic
  always_comb begin
    state_nxt = state_r;
    tmr_nxt   = '0;
    case (state_r)
      PCS_ST_OFF: begin
        if (on_req | on_pend_r) begin
          state_nxt = PCS_ST_SETTLE;
        end
      end
      PCS_ST_SETTLE: begin
        // Supply on, gate arrays kept in reset until settled
        if (tmr_settle_done) begin
          state_nxt = PCS_ST_ON;
        end else begin
          tmr_nxt = tmr_r + 1'b1;
        end
      end
      PCS_ST_ON: begin
        if (off_req | off_pend_r) begin
          state_nxt = PCS_ST_PREP;
        end
      end
      PCS_ST_PREP: begin
        // Supply held until software reports work closed out
        // No timeout: a hung processor keeps the rail up until reset
        if (cmd_off_ack) begin
          state_nxt = PCS_ST_DROP;
        end else if (on_req) begin
          state_nxt = PCS_ST_ON;
        end
      end
      PCS_ST_DROP: begin
        // Gate arrays in reset for a lead time before supply drops
        if (tmr_lead_done) begin
          state_nxt = PCS_ST_OFF;
        end else begin
          tmr_nxt = tmr_r + 1'b1;
        end
      end
      default: begin
        state_nxt = PCS_ST_OFF;
      end
    endcase
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      state_r <= PCS_ST_OFF;
      tmr_r   <= '0;
    end else begin
      state_r <= state_nxt;
      tmr_r   <= tmr_nxt;
    end
  end

  // Off requests arriving during settle and on requests arriving during drop are held for the next state
  // A late request is served once the running step ends; a power-on request in the same cycle as the off-ack is dropped
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      off_pend_r <= 1'b0;
      on_pend_r  <= 1'b0;
    end else begin
      off_pend_r <= (state_r == PCS_ST_SETTLE) & (off_req | off_pend_r);
      on_pend_r  <= (state_r == PCS_ST_DROP) & (on_req | on_pend_r);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Power and reset drives
  wire supply_on = (state_r != PCS_ST_OFF);
  wire ga_active = (state_r == PCS_ST_ON) | (state_r == PCS_ST_PREP);

  // All drives registered; reset levels keep the board unpowered and in reset
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      supply_enable_n      <= 1'b1;
      gate_array_reset_out <= 1'b0;
      cpu_reset_n          <= 1'b0;
      backup_select        <= 1'b0;
      lcd_drive_en         <= 1'b0;
    end else begin
      supply_enable_n      <= ~supply_on;
      // Reset only, power to the gate arrays follows the supply
      gate_array_reset_out <= ga_active & ~rst_press;
      cpu_reset_n          <= ga_active & ~rst_press;
      backup_select        <= ctrl_r[PCS_CTRL_BACKUP];
      // Display drive kept alive for the low-battery warning
      lcd_drive_en         <= ctrl_r[PCS_CTRL_BACKUP] | supply_on;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Main battery charge timer
  logic [PCS_CHG_CNT_W-1:0] chg_cnt_r;
  logic                     chg_done_r;
  logic                     chg_done_d_r;

  wire chg_restart = adp_rise | cmd_chg_rst;
  wire chg_expire  = (chg_cnt_r == CHARGE_CYCLES - 1'b1);

  // Counts from adaptor connect; restarts on reconnect or soft request
  // One span whatever the power state; every reconnect starts it afresh
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      chg_cnt_r  <= '0;
      chg_done_r <= 1'b0;
    end else if (chg_restart | ~pin_s.adaptor_present) begin
      chg_cnt_r  <= '0;
      chg_done_r <= 1'b0;
    end else if (!chg_done_r) begin
      chg_cnt_r  <= chg_cnt_r + 1'b1;
      chg_done_r <= chg_expire;
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      chg_done_d_r <= 1'b0;
    end else begin
      chg_done_d_r <= chg_done_r;
    end
  end

  wire trickle_ev = chg_done_r & ~chg_done_d_r;

  // Charge and measurement drives
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      main_charge_mode <= 1'b0;
      aux_charge_mode  <= 1'b0;
      battery_sense_en <= 1'b0;
    end else begin
      // Jumper closed forces normal charge; timer result then ignored
      main_charge_mode <= chg_done_r & pin_s.adaptor_present
                          & ~pin_s.charge_override_jumper;
      aux_charge_mode  <= ctrl_r[PCS_CTRL_AUX_TRK];
      battery_sense_en <= ctrl_r[PCS_CTRL_BSENSE];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupts
  logic [PCS_IRQ_N-1:0] irq_ev;

  always_comb begin
    irq_ev                  = '0;
    irq_ev[PCS_IRQ_SW_ON]   = sw_rise;
    irq_ev[PCS_IRQ_SW_OFF]  = sw_fall;
    irq_ev[PCS_IRQ_RST_REL] = rst_rel;
    irq_ev[PCS_IRQ_LOWVOLT] = lv_rise;
    irq_ev[PCS_IRQ_ADP_CHG] = adp_edge;
    irq_ev[PCS_IRQ_TRICKLE] = trickle_ev;
  end

  wire [PCS_IRQ_N-1:0] irq_clr = wr_irq_st ? bus.wdata[PCS_IRQ_N-1:0] : '0;

  // Sticky status, write one to clear; a new event beats the clear
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      irq_st_r <= PCS_IRQ_RST;
      irq_mk_r <= PCS_IRQ_RST;
    end else begin
      irq_st_r <= (irq_st_r & ~irq_clr) | irq_ev;
      if (wr_irq_mk) begin
        irq_mk_r <= bus.wdata[PCS_IRQ_N-1:0];
      end
    end
  end

  // Registered so the line never glitches while status and mask change
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_st_r & irq_mk_r);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read path
  logic [PCS_DATA_W-1:0] status_w;
  logic [PCS_DATA_W-1:0] rdata_nxt;

  // Status: sequencer state, charge state and live pin levels
  assign status_w = {pin_s.charge_override_jumper, pin_s.adaptor_present,
                     pin_s.reset_switch_n, pin_s.power_switch_in,
                     chg_done_r, state_r == PCS_ST_PREP, state_r == PCS_ST_ON,
                     supply_on};

  always_comb begin
    case (bus.addr)
      PCS_OFF_CTRL:   rdata_nxt = ctrl_r;
      PCS_OFF_STATUS: rdata_nxt = status_w;
      PCS_OFF_IRQ_ST: rdata_nxt = {2'h0, irq_st_r};
      PCS_OFF_IRQ_MK: rdata_nxt = {2'h0, irq_mk_r};
      default:        rdata_nxt = '0;
    endcase
  end

  // Data valid only the cycle after the read strobe
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      rdata <= '0;
    end else begin
      rdata <= bus.rd ? rdata_nxt : '0;
    end
  end

endmodule
`default_nettype wire

// *** verilog/pcs_pkg.sv ***
// Constants, field layouts and carrier types of the power and charge sequencer
package pcs_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Clock and timing
  localparam longint PCS_CLK_HZ          = 250_000_000;
  localparam longint PCS_CLK_PERIOD_PS   = 4_000;
  localparam longint PCS_NORMAL_CHG_HOURS = 8;
  localparam longint PCS_NORMAL_CHG_CYC  = PCS_NORMAL_CHG_HOURS * 3600 * PCS_CLK_HZ;
  localparam int     PCS_CHG_CNT_W       = 44;
  // Supply settle before releasing the gate-array reset (least time, round up)
  localparam longint PCS_SETTLE_NS       = 2_000;
  localparam longint PCS_SETTLE_CYC      = (PCS_SETTLE_NS * 1000 + PCS_CLK_PERIOD_PS - 1)
                                           / PCS_CLK_PERIOD_PS;
  // Gate-array reset lead ahead of supply removal (least time, round up)
  localparam longint PCS_GA_LEAD_NS      = 1_000;
  localparam longint PCS_GA_LEAD_CYC     = (PCS_GA_LEAD_NS * 1000 + PCS_CLK_PERIOD_PS - 1)
                                           / PCS_CLK_PERIOD_PS;
  localparam int     PCS_TMR_W           = 12;

  ////////////////////////////////////////////////////////////////////////////
  // Register map (byte addresses)
  localparam int       PCS_ADDR_W     = 8;
  localparam int       PCS_DATA_W     = 8;
  localparam bit [7:0] PCS_OFF_CTRL   = 8'h00;
  localparam bit [7:0] PCS_OFF_CMD    = 8'h04;
  localparam bit [7:0] PCS_OFF_STATUS = 8'h08;
  localparam bit [7:0] PCS_OFF_IRQ_ST = 8'h0C;
  localparam bit [7:0] PCS_OFF_IRQ_MK = 8'h10;

  // CTRL fields
  localparam int PCS_CTRL_BACKUP  = 0;
  localparam int PCS_CTRL_AUX_TRK = 1;
  localparam int PCS_CTRL_BSENSE  = 2;
  localparam bit [7:0] PCS_CTRL_RST = 8'h00;

  // CMD fields (write-only pulses)
  localparam int PCS_CMD_AUTO_ON  = 0;
  localparam int PCS_CMD_AUTO_OFF = 1;
  localparam int PCS_CMD_OFF_ACK  = 2;
  localparam int PCS_CMD_CHG_RST  = 3;

  // Interrupt status / mask fields
  localparam int PCS_IRQ_SW_ON    = 0;
  localparam int PCS_IRQ_SW_OFF   = 1;
  localparam int PCS_IRQ_RST_REL  = 2;
  localparam int PCS_IRQ_LOWVOLT  = 3;
  localparam int PCS_IRQ_ADP_CHG  = 4;
  localparam int PCS_IRQ_TRICKLE  = 5;
  localparam int PCS_IRQ_N        = 6;
  localparam bit [PCS_IRQ_N-1:0] PCS_IRQ_RST = 6'h00;

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer states
  typedef enum logic [4:0] {
    PCS_ST_OFF    = 5'h01,
    PCS_ST_SETTLE = 5'h02,
    PCS_ST_ON     = 5'h04,
    PCS_ST_PREP   = 5'h08,
    PCS_ST_DROP   = 5'h10
  } pcs_state_type;

  // Pins arriving from outside the clock domain
  typedef struct packed {
    logic power_switch_in;
    logic reset_switch_n;
    logic adaptor_present;
    logic charge_override_jumper;
    logic low_volt_det;
  } pcs_pins_type;
  localparam int PCS_PINS_W = 5;
  localparam bit [4:0] PCS_PINS_RST = 5'h08; // reset switch idle high

  // Register bus request
  typedef struct packed {
    logic [PCS_ADDR_W-1:0] addr;
    logic [PCS_DATA_W-1:0] wdata;
    logic                  wr;
    logic                  rd;
  } pcs_bus_type;

endpackage

// *** verilog/pcs_sync.sv ***
// Two-stage synchroniser for a group of asynchronous pin levels
`timescale 1ns/10ps
`default_nettype none
module pcs_sync #(
  parameter int           W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // Clock and reset
  input  wire logic         mclk,
  input  wire logic         sys_rst,
  // Levels
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] meta_r;

  // First stage read only by the second
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      meta_r   <= RST_VAL;
      sync_out <= RST_VAL;
    end else begin
      meta_r   <= async_in;
      sync_out <= meta_r;
    end
  end

endmodule
`default_nettype wire

// *** tb/pcs_top_asserts.sv ***
// Port-level assertions for the power and charge sequencer
`timescale 1ns/10ps
`default_nettype none
module pcs_top_asserts
  import pcs_pkg::*;
#(
  parameter logic [43:0] CHARGE_CYCLES = 44'h14
) (
  // Clock and reset
  input wire logic                  mclk,
  input wire logic                  sys_rst,
  // Pins and register port
  input wire pcs_pkg::pcs_pins_type pins,
  input wire pcs_pkg::pcs_bus_type  bus,
  // Drives
  input wire logic                  supply_enable_n,
  input wire logic                  gate_array_reset_out,
  input wire logic                  cpu_reset_n,
  input wire logic                  backup_select,
  input wire logic                  lcd_drive_en,
  input wire logic                  main_charge_mode,
  input wire logic                  aux_charge_mode,
  input wire logic                  battery_sense_en
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  ////////////////////////////////////////////////////////////
  // Off-ack seen while the rail is up; age of the adaptor connection
  logic        ack_r;
  logic        ack_nxt;
  logic [43:0] age_r;
  logic [43:0] age_nxt;
  assign ack_nxt = (bus.wr && bus.addr == PCS_OFF_CMD && bus.wdata[PCS_CMD_OFF_ACK])
                   || (ack_r && !supply_enable_n);
  assign age_nxt = (!pins.adaptor_present || (bus.wr && bus.addr == PCS_OFF_CMD
                   && bus.wdata[PCS_CMD_CHG_RST])) ? 44'h0
                 : (age_r == CHARGE_CYCLES + 44'h8) ? age_r : age_r + 44'h1;
  // Saturating age keeps the count small whatever the run length
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      ack_r <= 1'b0;
      age_r <= 44'h0;
    end else begin
      ack_r <= ack_nxt;
      age_r <= age_nxt;
    end
  end
  // Steps of the switch-on and reset-switch behaviours
  sequence sw_rise;
    $rose(pins.power_switch_in) && supply_enable_n && !gate_array_reset_out;
  endsequence
  sequence rail_off2;
    supply_enable_n [*2];
  endsequence
  sequence rst_held;
    !pins.reset_switch_n [*4];
  endsequence
  a_switch_on: assert property (
    sw_rise ##0 rail_off2 |-> ##[1:4] !supply_enable_n) else $error("switch on late");
  a_ga_lead: assert property (
    $rose(supply_enable_n) |-> $past(gate_array_reset_out, 8) == 1'b0)
    else $error("rail dropped before gate reset");
  a_ga_release: assert property (
    $rose(gate_array_reset_out) |-> $past(supply_enable_n, 8) == 1'b0)
    else $error("gate reset released early");
  a_off_ack: assert property (
    $rose(supply_enable_n) |-> ack_r) else $error("rail dropped without ack");
  a_cpu_off: assert property (
    supply_enable_n |-> !cpu_reset_n) else $error("cpu runs with rail off");
  a_rst_switch: assert property (
    rst_held |-> !cpu_reset_n && !gate_array_reset_out) else $error("reset switch ignored");
  a_ctrl_pins: assert property (
    bus.wr && bus.addr == PCS_OFF_CTRL |=> ##1
    {5'h00, battery_sense_en, aux_charge_mode, backup_select} == ($past(bus.wdata, 2) & 8'h07))
    else $error("control pins wrong");
  a_lcd_backup: assert property (
    backup_select && $past(backup_select) |-> lcd_drive_en) else $error("display drive lost");
  a_chg_normal: assert property (
    age_r < CHARGE_CYCLES |-> !main_charge_mode) else $error("trickle too early");
  a_chg_trickle: assert property (
    age_r == CHARGE_CYCLES + 44'h8 && !pins.charge_override_jumper
    && $past(pins.charge_override_jumper, 4) == 1'b0 |-> main_charge_mode)
    else $error("trickle missing");
  a_override: assert property (
    pins.charge_override_jumper [*4] |-> !main_charge_mode) else $error("override ignored");
endmodule
bind pcs_top pcs_top_asserts #(.CHARGE_CYCLES(CHARGE_CYCLES)) u_asserts (
  .mclk(mclk), .sys_rst(sys_rst), .pins(pins), .bus(bus),
  .supply_enable_n(supply_enable_n), .gate_array_reset_out(gate_array_reset_out),
  .cpu_reset_n(cpu_reset_n), .backup_select(backup_select), .lcd_drive_en(lcd_drive_en),
  .main_charge_mode(main_charge_mode), .aux_charge_mode(aux_charge_mode),
  .battery_sense_en(battery_sense_en));
`default_nettype wire

// *** tb/pcs_partner.sv ***
// Model of the supply switch, main charger and gate-array reset targets
`timescale 1ns/10ps
`default_nettype none
module pcs_partner (
  // Drives from the sequencer
  input  wire logic supply_enable_n,
  input  wire logic gate_array_reset_out,
  input  wire logic main_charge_mode,
  // Charger conditions
  input  wire logic adaptor_present,
  input  wire logic charge_override_jumper,
  // Observed effect
  output logic      logic_supply,
  output logic      normal_charge,
  output logic      ga_in_reset
);
  // Switch transistors feed the rail only while the enable is low
  assign logic_supply  = !supply_enable_n;
  // Jumper bypass or low mode gives full current; no adaptor, no charge
  assign normal_charge = adaptor_present
                         && (charge_override_jumper || !main_charge_mode);
  // Companion chips sit in init while the line is low
  assign ga_in_reset   = !gate_array_reset_out;
endmodule
`default_nettype wire

// *** tb/pcs_top_tb.sv ***
// Self-checking bench for the power and charge sequencer
`timescale 1ns/10ps
`default_nettype none
module pcs_top_tb;
  import pcs_pkg::*;
  // Short charge span keeps the run small
  localparam logic [43:0] CHG = 44'h14;
  localparam int O_SUP = 7;
  localparam int O_GA  = 6;
  localparam int O_CPU = 5;
  localparam int O_LCD = 3;
  localparam int O_MCM = 2;
  logic         mclk;
  logic         sys_rst;
  pcs_pins_type pins;
  pcs_bus_type  bus;
  logic [7:0]   rdata;
  logic         irq;
  wire  [7:0]   outs;
  wire  [2:0]   far;
  logic [7:0]   rv;
  int           mismatches;
  int           total_checks;
  int           cycles;
  pcs_top #(.CHARGE_CYCLES(CHG)) u_dut (
    .mclk(mclk), .sys_rst(sys_rst), .pins(pins), .bus(bus), .rdata(rdata), .irq(irq),
    .supply_enable_n(outs[7]), .gate_array_reset_out(outs[6]), .cpu_reset_n(outs[5]),
    .backup_select(outs[4]), .lcd_drive_en(outs[3]), .main_charge_mode(outs[2]),
    .aux_charge_mode(outs[1]), .battery_sense_en(outs[0]));
  pcs_partner u_partner (
    .supply_enable_n(outs[7]), .gate_array_reset_out(outs[6]), .main_charge_mode(outs[2]),
    .adaptor_present(pins.adaptor_present), .charge_override_jumper(pins.charge_override_jumper),
    .logic_supply(far[0]), .normal_charge(far[1]), .ga_in_reset(far[2]));
  ////////////////////////////////////////////////////////////
  // Clock and hang guard
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches = mismatches + 1;
      close_out();
    end
  end
  task automatic close_out();
    if (mismatches == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // Bus cycles: one-cycle strobes launched just after an edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge mclk);
    bus.wr <= 1'b0;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
    @(posedge mclk);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge mclk);
    bus.rd <= 1'b0;
    #1 rv = rdata;
    chk(rv & m, e);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  // Bounded wait on one drive, then compare it
  task automatic wait_out(input int w, input logic v, input int lim);
    int n;
    n = 0;
    while (outs[w] !== v && n < lim) begin
      @(posedge mclk);
      #1 n++;
    end
    chk({7'h00, outs[w]}, {7'h00, v});
  endtask
  ////////////////////////////////////////////////////////////
  // Quiet state out of reset, plus an unmapped read
  task automatic t_reset();
    chk(outs, 8'h80);
    chk({5'h00, far}, 8'h04);
    rdchk(PCS_OFF_CTRL, 8'hFF, 8'h00);
    rdchk(8'h14, 8'hFF, 8'h00);
  endtask
  // Control bits to backup, aux charge and sense; display drive follows backup
  task automatic t_ctrl();
    logic [7:0] pat [5] = '{8'h01, 8'h02, 8'h04, 8'h07, 8'h00};
    for (int i = 0; i < 5; i++) begin
      wr(PCS_OFF_CTRL, pat[i]);
      cyc(2);
      chk({5'h00, outs[0], outs[1], outs[4]}, pat[i]);
      chk({7'h00, outs[O_LCD]}, {7'h00, pat[i][0]});
      rdchk(PCS_OFF_CTRL, 8'hFF, pat[i]);
    end
  endtask
  // Switch on: rail first, resets after settle; event raised, masked, cleared
  task automatic t_power_on();
    wr(PCS_OFF_IRQ_MK, 8'h3F);
    @(posedge mclk) pins.power_switch_in <= 1'b1;
    wait_out(O_SUP, 1'b0, 8);
    chk({7'h00, outs[O_GA]}, 8'h00);
    wait_out(O_GA, 1'b1, 600);
    chk({6'h00, outs[O_CPU], far[2]}, 8'h02);
    chk({7'h00, irq}, 8'h01);
    wr(PCS_OFF_IRQ_MK, 8'h00);
    cyc(3);
    chk({7'h00, irq}, 8'h00);
    rdchk(PCS_OFF_IRQ_ST, 8'h01, 8'h01);
    wr(PCS_OFF_IRQ_ST, 8'h3F);
    rdchk(PCS_OFF_IRQ_ST, 8'h3F, 8'h00);
  endtask
  // Reset switch while running pulls both resets and leaves the rail alone
  task automatic t_rst_switch();
    @(posedge mclk) pins.reset_switch_n <= 1'b0;
    cyc(5);
    chk(outs & 8'hE0, 8'h00);
    @(posedge mclk) pins.reset_switch_n <= 1'b1;
    wait_out(O_CPU, 1'b1, 10);
    rdchk(PCS_OFF_IRQ_ST, 8'h04, 8'h04);
  endtask
  // Ack: gate reset drops ahead of the rail
  task automatic off_ack();
    wr(PCS_OFF_CMD, 8'h04);
    wait_out(O_GA, 1'b0, 8);
    chk({7'h00, outs[O_SUP]}, 8'h00);
    wait_out(O_SUP, 1'b1, 300);
    chk({7'h00, far[0]}, 8'h00);
  endtask
  // Switch off holds the rail until software acknowledges
  task automatic t_power_off();
    @(posedge mclk) pins.power_switch_in <= 1'b0;
    cyc(60);
    chk({7'h00, outs[O_SUP]}, 8'h00);
    rdchk(PCS_OFF_STATUS, 8'h07, 8'h05);
    rdchk(PCS_OFF_IRQ_ST, 8'h02, 8'h02);
    off_ack();
  endtask
  // Soft power on, then off by low voltage and by the soft command
  task automatic t_soft();
    for (int k = 0; k < 2; k++) begin
      wr(PCS_OFF_CMD, 8'h01);
      wait_out(O_GA, 1'b1, 600);
      if (k == 0) begin
        @(posedge mclk) pins.low_volt_det <= 1'b1;
      end else begin
        wr(PCS_OFF_CMD, 8'h02);
      end
      cyc(8);
      rdchk(PCS_OFF_STATUS, 8'h07, 8'h05);
      off_ack();
      @(posedge mclk) pins.low_volt_det <= 1'b0;
    end
  endtask
  // Adaptor in: normal for the timer span, then trickle; jumper forces normal
  task automatic t_charge();
    @(posedge mclk) pins.adaptor_present <= 1'b1;
    cyc(8);
    rdchk(PCS_OFF_STATUS, 8'h40, 8'h40);
    chk({6'h00, outs[O_MCM], far[1]}, 8'h01);
    wait_out(O_MCM, 1'b1, 40);
    chk({7'h00, far[1]}, 8'h00);
    rdchk(PCS_OFF_IRQ_ST, 8'h30, 8'h30);
    @(posedge mclk) pins.charge_override_jumper <= 1'b1;
    cyc(6);
    chk({6'h00, outs[O_MCM], far[1]}, 8'h01);
    // Soft restart of the timer, then jumper open: normal again for a full span
    wr(PCS_OFF_CMD, 8'h08);
    @(posedge mclk) pins.charge_override_jumper <= 1'b0;
    cyc(8);
    chk({6'h00, outs[O_MCM], far[1]}, 8'h01);
    wait_out(O_MCM, 1'b1, 40);
    @(posedge mclk) pins <= PCS_PINS_RST;
  endtask
  // Main sequence
  initial begin
    sys_rst = 1'b1;
    pins = PCS_PINS_RST;
    bus = '0;
    mismatches = 0;
    total_checks = 0;
    cycles = 0;
    repeat (2) @(posedge mclk);
    sys_rst <= 1'b0;
    #1;
    t_reset();
    t_ctrl();
    t_power_on();
    t_rst_switch();
    t_power_off();
    t_soft();
    t_charge();
    close_out();
  end
endmodule
`default_nettype wire
